// ===== logic/cifs_pkg.sv
/*
 * constants and carrier types of the card interface status flag block.
 * assumes one peripheral clock and an apb master with 32-bit data.
 */
package cifs_pkg;

   // ***************************************************************
   // register byte addresses
   // ***************************************************************
   localparam logic [11:0] CMD_OFF = 12'h014;
   localparam logic [11:0] SR_OFF = 12'h040;
   localparam logic [11:0] CFG_OFF = 12'h054;
   localparam logic [11:0] IEN_OFF = 12'h060;
   localparam logic [11:0] IST_OFF = 12'h064;
   localparam logic [11:0] ICLR_OFF = 12'h068;

   // ***************************************************************
   // status field positions
   // ***************************************************************
   localparam int UNDERRUN_BIT = 31;
   localparam int OVERRUN_BIT = 30;
   localparam int BOOT_ACK_ERR_BIT = 29;
   localparam int BOOT_ACK_RCV_BIT = 28;
   localparam int XFER_DONE_BIT = 27;
   localparam int RX_EMPTY_BIT = 26;
   localparam int BLK_OVR_BIT = 24;
   localparam int ERR_LSB = 16;
   localparam int CS_RCV_BIT = 13;
   localparam int READ_WAIT_BIT = 12;
   localparam int SDIO_IRQ_BIT = 8;
   localparam int NOT_BUSY_BIT = 5;
   localparam int IN_PROG_BIT = 4;
   localparam int BLK_END_BIT = 3;
   localparam int TX_RDY_BIT = 2;
   localparam int RX_RDY_BIT = 1;
   localparam int CMD_RDY_BIT = 0;
   localparam int CFG_MODE_BIT = 4;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [31:0] SR_RESET = 32'h0000c0e5;
   localparam logic [31:0] RSV_ONES = 32'h0000c0c0; // unnamed bits of the reset image
   localparam logic [31:0] IEN_RESET = 32'h00000000;
   localparam logic CFG_MODE_RESET = 1'h0;

   // level status presented by the card controller core
   typedef struct packed {
      logic boot_ack_received;
      logic transfer_done;
      logic rx_fifo_empty;
      logic block_overrun_error;
      logic [7:0] err; // completion timeout down to response index error
      logic completion_signal_received;
      logic sdio_read_wait;
      logic transfer_in_progress;
      logic block_ended;
      logic transmit_ready;
      logic receive_ready;
      logic command_ready;
   } cifs_core_t;

   // one-cycle error events from the card controller core
   typedef struct packed {
      logic underrun_error;
      logic overrun_error;
      logic boot_ack_error;
   } cifs_evt_t;

endpackage : cifs_pkg

// ===== logic/cifs_sync.sv
/*
 * three-stage input synchroniser with agreement filter.
 * assumes an asynchronous pin and the peripheral clock.
 */
module cifs_sync #(
   parameter logic RST_VAL = 1'h1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic q
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } cifs_sync_st_t;

   cifs_sync_st_t r;
   cifs_sync_st_t next_r;

   // s1 feeds only s2; a change is taken once s2 and s3 agree
   always_comb begin
      next_r = r;
      next_r.s1 = pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      if (r.s2 == r.s3) begin
         next_r.q = r.s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= {4{RST_VAL}};
      end else begin
         r <= next_r;
      end
   end

   assign q = r.q;

   a_sync_agree: assert property (@(posedge pclk) disable iff (!presetn)
      (r.s2 == r.s3) |=> (q == $past(r.s3))) else $error("synchroniser ignored agreement");
endmodule : cifs_sync

// ===== logic/cifs_flag.sv
/*
 * sticky flag: a set pulse wins over a clear in the same cycle.
 * assumes set and clear come from logic on the same clock.
 */
module cifs_flag (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set,
   input wire logic clr,
   output logic q
);
   typedef struct packed {
      logic q;
   } cifs_flag_st_t;

   cifs_flag_st_t r;
   cifs_flag_st_t next_r;

   // set has priority so an event in the clearing cycle survives
   always_comb begin
      next_r = r;
      if (set) begin
         next_r.q = 1'h1;
      end else if (clr) begin
         next_r.q = 1'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.q;

   a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      set |=> q) else $error("flag lost a set");
   a_clear_takes: assert property (@(posedge pclk) disable iff (!presetn)
      (clr && !set) |=> !q) else $error("flag ignored a clear");
endmodule : cifs_flag

// ===== logic/cifs_status_flags.sv
/*
 * status flag register bank of a memory card interface, apb slave.
 * assumes the controller core drives levels and event pulses on pclk,
 * and that the card data lines 0 and 1 arrive asynchronously on pins.
 */

// Overview of operation
// - underrun event sets sticky flag bit 31
// - overrun event sets sticky flag bit 30
// - clear mode picks read-clear or command-write clear
// - boot ack error bit 29 clears on read
// - bits 28,27,26,24 report boot, done, fifo, overrun
// - bits 23..16 errors; 13,12,8 completion, wait, irq
// - low byte flags; reset image 0xc0e5
module cifs_status_flags (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire cifs_pkg::cifs_core_t core,
   input wire cifs_pkg::cifs_evt_t evt,
   input wire logic card_dat0,
   input wire logic card_dat1,
   output logic irq
);
   import cifs_pkg::*;

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic mode;
      logic [31:0] ien;
      logic [31:0] lvl;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } cifs_top_st_t;

   cifs_top_st_t r;
   cifs_top_st_t next_r;

   logic not_busy;
   logic dat1_high;
   logic setup;
   logic done;
   logic wr;
   logic rd;
   logic hit_cmd;
   logic hit_sr;
   logic hit_cfg;
   logic hit_ien;
   logic hit_ist;
   logic hit_iclr;
   logic mapped;
   logic cmd_wr;
   logic sr_rd;
   logic [2:0] err_q;
   logic [2:0] err_set;
   logic [2:0] err_clr;
   logic [31:0] sr_word;
   logic [31:0] lvl_now;
   logic [31:0] ist;
   logic [31:0] int_evt;
   logic [31:0] int_clr;

   // ***************************************************************
   // card pins
   // ***************************************************************
   // data line 0 high means the card has released busy
   cifs_sync #(
      .RST_VAL(1'h1)
   ) u_sync_dat0 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(card_dat0),
      .q(not_busy)
   );

   // data line 1 pulled low by the card signals an sdio interrupt
   cifs_sync #(
      .RST_VAL(1'h1)
   ) u_sync_dat1 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(card_dat1),
      .q(dat1_high)
   );

   // ***************************************************************
   // apb decode
   // ***************************************************************
   // one access cycle: pready rises the cycle after setup
   assign setup = psel && !penable;
   assign done = psel && penable && r.pready;
   assign wr = done && pwrite && !r.pslverr;
   assign rd = done && !pwrite && !r.pslverr;

   assign hit_cmd = (paddr == CMD_OFF);
   assign hit_sr = (paddr == SR_OFF);
   assign hit_cfg = (paddr == CFG_OFF);
   assign hit_ien = (paddr == IEN_OFF);
   assign hit_ist = (paddr == IST_OFF);
   assign hit_iclr = (paddr == ICLR_OFF);
   assign mapped = hit_cmd || hit_sr || hit_cfg || hit_ien || hit_ist || hit_iclr;

   assign cmd_wr = wr && hit_cmd;
   assign sr_rd = rd && hit_sr;

   // ***************************************************************
   // level status image
   // ***************************************************************
   // levels are registered so the read word comes from flip-flops
   always_comb begin
      lvl_now = RSV_ONES;
      lvl_now[BOOT_ACK_RCV_BIT] = core.boot_ack_received;
      lvl_now[XFER_DONE_BIT] = core.transfer_done;
      lvl_now[RX_EMPTY_BIT] = core.rx_fifo_empty;
      lvl_now[BLK_OVR_BIT] = core.block_overrun_error;
      lvl_now[ERR_LSB +: 8] = core.err;
      lvl_now[CS_RCV_BIT] = core.completion_signal_received;
      lvl_now[READ_WAIT_BIT] = core.sdio_read_wait;
      lvl_now[SDIO_IRQ_BIT] = !dat1_high;
      lvl_now[NOT_BUSY_BIT] = not_busy;
      lvl_now[IN_PROG_BIT] = core.transfer_in_progress;
      lvl_now[BLK_END_BIT] = core.block_ended;
      lvl_now[TX_RDY_BIT] = core.transmit_ready;
      lvl_now[RX_RDY_BIT] = core.receive_ready;
      lvl_now[CMD_RDY_BIT] = core.command_ready;
   end

   // ***************************************************************
   // sticky error flags
   // ***************************************************************
   // each error pulse feeds its own sticky flag: 2 underrun, 1 overrun, 0 boot ack
   assign err_set = {evt.underrun_error, evt.overrun_error, evt.boot_ack_error};

   // a read clears only the bits that it actually returned, so an event landing
   // between setup and access of a read is never lost; in mode 1 a command write clears underrun and overrun whatever was read
   always_comb begin
      if (r.mode) begin
         err_clr[2] = cmd_wr;
         err_clr[1] = cmd_wr;
      end else begin
         err_clr[2] = sr_rd && r.prdata[UNDERRUN_BIT];
         err_clr[1] = sr_rd && r.prdata[OVERRUN_BIT];
      end
      err_clr[0] = sr_rd && r.prdata[BOOT_ACK_ERR_BIT];
   end

   // one set-wins flag per error bit, so a pulse in the clearing cycle survives
   for (genvar e = 0; e < 3; e++) begin : g_err
      cifs_flag u_err (
         .pclk(pclk),
         .presetn(presetn),
         .set(err_set[e]),
         .clr(err_clr[e]),
         .q(err_q[e])
      );
   end

   // the full status word as software sees it
   always_comb begin
      sr_word = r.lvl;
      sr_word[UNDERRUN_BIT] = err_q[2];
      sr_word[OVERRUN_BIT] = err_q[1];
      sr_word[BOOT_ACK_ERR_BIT] = err_q[0];
   end

   // ***************************************************************
   // interrupt status
   // ***************************************************************
   // events are rising status levels and the error pulses
   always_comb begin
      int_evt = lvl_now & ~r.lvl;
      int_evt[UNDERRUN_BIT] = evt.underrun_error;
      int_evt[OVERRUN_BIT] = evt.overrun_error;
      int_evt[BOOT_ACK_ERR_BIT] = evt.boot_ack_error;
   end

   // write-one-to-clear, acting only on the completing access edge
   assign int_clr = (wr && hit_iclr) ? pwdata : 32'h00000000;

   // every status bit owns an interrupt flag; the constant-one filler never rises
   for (genvar i = 0; i < 32; i++) begin : g_int
      cifs_flag u_int (
         .pclk(pclk),
         .presetn(presetn),
         .set(int_evt[i]),
         .clr(int_clr[i]),
         .q(ist[i])
      );
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      next_r = r;
      next_r.lvl = lvl_now;
      next_r.pready = setup;
      next_r.pslverr = setup && (!mapped || (pwrite && (hit_sr || hit_ist)));
      next_r.irq = |(ist & r.ien);
      // read data is latched in setup; write-only words read as zero
      if (setup && !pwrite) begin
         case (1'b1)
            hit_sr: begin
               next_r.prdata = sr_word;
            end
            hit_cfg: begin
               next_r.prdata = 32'h00000000;
               next_r.prdata[CFG_MODE_BIT] = r.mode;
            end
            hit_ien: begin
               next_r.prdata = r.ien;
            end
            hit_ist: begin
               next_r.prdata = ist;
            end
            default: begin
               next_r.prdata = 32'h00000000;
            end
         endcase
      end
      // writes take effect on the completing access edge only
      if (wr && hit_cfg) begin
         next_r.mode = pwdata[CFG_MODE_BIT];
      end
      if (wr && hit_ien) begin
         next_r.ien = pwdata;
      end
   end

   // reset loads constants only; the level image starts at the reset word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r.mode <= CFG_MODE_RESET;
         r.ien <= IEN_RESET;
         r.lvl <= SR_RESET;
         r.prdata <= 32'h00000000;
         r.pready <= 1'h0;
         r.pslverr <= 1'h0;
         r.irq <= 1'h0;
      end else begin
         r <= next_r;
      end
   end

   // outputs come straight from the state flip-flops
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign irq = r.irq;

   // ***************************************************************
   // checks
   // ***************************************************************
   // helper: high only in the first cycle after reset release
   logic fresh;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fresh <= 1'h1;
      end else begin
         fresh <= 1'h0;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ready_timing: assert property (setup |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   a_underrun_set: assert property (evt.underrun_error |=> sr_word[UNDERRUN_BIT])
      else $error("underrun event not reported");
   a_overrun_set: assert property (evt.overrun_error |=> sr_word[OVERRUN_BIT])
      else $error("overrun event not reported");
   a_read_clear: assert property (sr_rd && !r.mode && r.prdata[OVERRUN_BIT]
      && !evt.overrun_error |=> !sr_word[OVERRUN_BIT]) else $error("overrun not cleared by read");
   a_cmd_clear: assert property (cmd_wr && r.mode && !evt.underrun_error
      |=> !sr_word[UNDERRUN_BIT]) else $error("underrun not cleared by command write");
   a_read_keeps: assert property (sr_rd && r.mode && err_q[2] && !cmd_wr
      |=> sr_word[UNDERRUN_BIT]) else $error("underrun cleared by read in command mode");
   a_boot_err_read: assert property (sr_rd && r.prdata[BOOT_ACK_ERR_BIT] && !evt.boot_ack_error
      |=> !sr_word[BOOT_ACK_ERR_BIT]) else $error("boot ack error not cleared by read");
   a_upper_map: assert property (##1 (sr_word[XFER_DONE_BIT] == $past(core.transfer_done))
      && (sr_word[BLK_OVR_BIT] == $past(core.block_overrun_error)))
      else $error("upper status bits misplaced");
   a_error_map: assert property (##1 sr_word[23:16] == $past(core.err))
      else $error("error byte misplaced");
   a_low_map: assert property (##1 (sr_word[CMD_RDY_BIT] == $past(core.command_ready))
      && (sr_word[TX_RDY_BIT] == $past(core.transmit_ready))) else $error("low byte misplaced");
   a_reset_image: assert property (fresh |-> sr_word == SR_RESET)
      else $error("status reset image wrong");
   a_irq_level: assert property (##1 irq == $past(|(ist & r.ien)))
      else $error("interrupt line does not follow enabled status");

   // bus answers: refusals, read data held between reads
   a_write_refused: assert property (setup && pwrite && (hit_sr || hit_ist) |=> pslverr && pready)
      else $error("write to a read-only word not refused");
   a_bad_address: assert property (setup && !mapped |=> pslverr)
      else $error("unmapped address not refused");
   a_bad_read_zero: assert property (setup && !pwrite && !mapped |=> prdata == 32'h00000000)
      else $error("unmapped read returned data");
   a_good_access: assert property (setup && mapped && !(pwrite && (hit_sr || hit_ist)) |=> !pslverr)
      else $error("legal access refused");
   a_read_hold: assert property (!(setup && !pwrite) |=> $stable(prdata))
      else $error("read data changed outside a read setup");

   // sticky error flags
   a_boot_err_set: assert property (evt.boot_ack_error |=> sr_word[BOOT_ACK_ERR_BIT])
      else $error("boot ack error not reported");
   a_underrun_read: assert property (sr_rd && !r.mode && r.prdata[UNDERRUN_BIT]
      && !evt.underrun_error |=> !sr_word[UNDERRUN_BIT]) else $error("underrun not cleared by read");
   a_overrun_cmd: assert property (cmd_wr && r.mode && !evt.overrun_error
      |=> !sr_word[OVERRUN_BIT]) else $error("overrun not cleared by command write");
   a_cfg_write: assert property (wr && hit_cfg |=> r.mode == $past(pwdata[CFG_MODE_BIT]))
      else $error("clear mode not written");

   // status map
   a_mid_map: assert property (##1 (sr_word[CS_RCV_BIT] == $past(core.completion_signal_received))
      && (sr_word[READ_WAIT_BIT] == $past(core.sdio_read_wait)))
      else $error("completion or read wait misplaced");
   a_boot_rcv_map: assert property (##1 (sr_word[BOOT_ACK_RCV_BIT] == $past(core.boot_ack_received))
      && (sr_word[RX_EMPTY_BIT] == $past(core.rx_fifo_empty)))
      else $error("boot ack or fifo empty misplaced");
   a_low_rest: assert property (##1 (sr_word[IN_PROG_BIT] == $past(core.transfer_in_progress))
      && (sr_word[BLK_END_BIT] == $past(core.block_ended))
      && (sr_word[RX_RDY_BIT] == $past(core.receive_ready))) else $error("low status flags misplaced");
   a_pin_map: assert property (##1 (sr_word[NOT_BUSY_BIT] == $past(not_busy))
      && (sr_word[SDIO_IRQ_BIT] == !$past(dat1_high)))
      else $error("card pin status misplaced");
   a_filler_ones: assert property ((sr_word & RSV_ONES) == RSV_ONES)
      else $error("filler bits of status not one");

   c_read_error: cover property (sr_rd && r.prdata[UNDERRUN_BIT]);
   c_cmd_clear: cover property (cmd_wr && r.mode && err_q[1]);
   c_irq_rise: cover property ($rose(irq));
   c_set_on_clear: cover property (err_clr[0] && err_set[0]);
   c_mode_one_read: cover property (sr_rd && r.mode && err_q[2]);
endmodule : cifs_status_flags

// ===== test/cifs_card_model.sv
/*
 * behavioural memory card as seen on the two status pins.
 * assumes the bench commands busy and interrupt phases; pins idle high
 * (pulled up), so an idle card reads not busy and no interrupt.
 */
module cifs_card_model (
   input wire logic busy,
   input wire logic irq_req,
   output logic card_dat0,
   output logic card_dat1
);
   timeunit 1ns;
   timeprecision 1ps;

   // a busy card holds line 0 low; an interrupt pulls line 1 low
   assign card_dat0 = ~busy;
   assign card_dat1 = ~irq_req;
endmodule : cifs_card_model

// ===== test/testbench.sv
/*
 * self-checking bench of the card interface status flag bank.
 * assumes a zero-wait apb slave, same-clock core levels and event pulses,
 * and the card model on the two asynchronous pins.
 */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import cifs_pkg::*;

   // ***************************************************************
   // signals and instances
   // ***************************************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   cifs_core_t core = cifs_core_t'(19'h00005);
   cifs_evt_t evt = '0;
   logic card_dat0;
   logic card_dat1;
   logic irq;
   logic busy = 1'b0;
   logic irq_req = 1'b0;
   int fails = 0;
   int n_checks = 0;
   logic [31:0] base;

   cifs_status_flags i_cifs_status_flags (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .core(core), .evt(evt), .card_dat0(card_dat0), .card_dat1(card_dat1), .irq(irq));
   cifs_card_model i_cifs_card_model (.busy(busy), .irq_req(irq_req), .card_dat0(card_dat0),
      .card_dat1(card_dat1));

   // 200 MHz clock
   initial begin
      forever #2.5 pclk = ~pclk;
   end

   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // one apb transfer; the request holds until the rising edge that samples pready high,
   // where read data and error are taken; only the watchdog ends a wait
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
         output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_e);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h00000000, q, e);
      chk("read data", exp, q);
      chk("read error", {31'h0, exp_e}, {31'h0, e});
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_e);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
      chk("write error", {31'h0, exp_e}, {31'h0, e});
   endtask : wr

   // one-cycle event pulse from the core
   task automatic pulse(input cifs_evt_t v);
      @(posedge pclk);
      evt <= v;
      @(posedge pclk);
      evt <= '0;
   endtask : pulse

   // status bit that shows a given core level bit
   function automatic int map_bit(input int j);
      if (j <= 4) return j;
      if (j == 5) return 12;
      if (j == 6) return 13;
      if (j <= 14) return j + 9;
      if (j == 15) return 24;
      return j + 10;
   endfunction : map_bit

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // watchdog: the sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      give_verdict();
   end

   // ***************************************************************
   // test sequence
   // ***************************************************************
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      base = RSV_ONES | 32'h00000020;
      rd(SR_OFF, SR_RESET, 1'b0);
      rd(IEN_OFF, IEN_RESET, 1'b0);
      rd(CFG_OFF, 32'h00000000, 1'b0);
      // every core level alone lands on its own status bit
      for (int j = 0; j < 19; j++) begin
         @(posedge pclk);
         core <= cifs_core_t'(19'h00001 << j);
         repeat (2) @(posedge pclk);
         rd(SR_OFF, base | (32'h1 << map_bit(j)), 1'b0);
      end
      @(posedge pclk);
      core <= cifs_core_t'(19'h00005);
      // card busy drops not-busy, card interrupt raises the sdio bit
      busy <= 1'b1;
      irq_req <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(SR_OFF, RSV_ONES | 32'h00000105, 1'b0);
      busy <= 1'b0;
      irq_req <= 1'b0;
      repeat (8) @(posedge pclk);
      // clear mode 0: error flags go on the read that returned them
      pulse('{underrun_error: 1'b1, overrun_error: 1'b1, boot_ack_error: 1'b1});
      rd(SR_OFF, SR_RESET | 32'he0000000, 1'b0);
      rd(SR_OFF, SR_RESET, 1'b0);
      // clear mode 1: reads leave underrun and overrun, a command write clears them; boot ack error still clears on read
      wr(CFG_OFF, 32'h00000010, 1'b0);
      rd(CFG_OFF, 32'h00000010, 1'b0);
      pulse('{underrun_error: 1'b1, overrun_error: 1'b0, boot_ack_error: 1'b1});
      pulse('{underrun_error: 1'b0, overrun_error: 1'b1, boot_ack_error: 1'b0});
      rd(SR_OFF, SR_RESET | 32'he0000000, 1'b0);
      rd(SR_OFF, SR_RESET | 32'hc0000000, 1'b0);
      wr(CMD_OFF, 32'h00000000, 1'b0);
      rd(SR_OFF, SR_RESET, 1'b0);
      // interrupt: raise, mask, unmask, clear
      wr(ICLR_OFF, 32'hffffffff, 1'b0);
      rd(IST_OFF, 32'h00000000, 1'b0);
      wr(IEN_OFF, 32'h80000000, 1'b0);
      rd(IEN_OFF, 32'h80000000, 1'b0);
      chk("irq idle", 32'h0, {31'h0, irq});
      pulse('{underrun_error: 1'b1, overrun_error: 1'b0, boot_ack_error: 1'b0});
      repeat (3) @(posedge pclk);
      chk("irq raised", 32'h1, {31'h0, irq});
      rd(IST_OFF, 32'h80000000, 1'b0);
      wr(IEN_OFF, 32'h00000000, 1'b0);
      repeat (3) @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(IEN_OFF, 32'h80000000, 1'b0);
      repeat (3) @(posedge pclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(ICLR_OFF, 32'h80000000, 1'b0);
      repeat (3) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd(IST_OFF, 32'h00000000, 1'b0);
      // refused and write-only places
      wr(SR_OFF, 32'hffffffff, 1'b1);
      rd(SR_OFF, SR_RESET | 32'h80000000, 1'b0);
      rd(12'h100, 32'h00000000, 1'b1);
      wr(12'h044, 32'h00000001, 1'b1);
      rd(CMD_OFF, 32'h00000000, 1'b0);
      rd(ICLR_OFF, 32'h00000000, 1'b0);
      give_verdict();
   end
endmodule : testbench
